// >>> rtl/field_point_params.svh
`ifndef FIELD_POINT_PARAMS_SVH
`define FIELD_POINT_PARAMS_SVH

`define FP_COUNT        12
`define FORCE_FLAG_OFS  4'hc
`define FORCE_VALUE_OFS 4'hd
`define FORCE_REQ_BIT   15
`define FORCE_SEL_MSB   11
`define VALUE_MAX       16'h270f
`define VALUE_RST       16'h0000
`define DP_RST          2'h0
`define BASE_RST        16'h0000

`endif

// >>> rtl/field_point_pkg.sv
package field_point_pkg;
  typedef logic [15:0] value_t;
  typedef logic [3:0]  entry_idx_t;
  typedef enum logic {LINK_RS232, LINK_RS422} link_mode_t;
  typedef enum {ST_PT, ST_PT_W, ST_FLG, ST_FLG_W, ST_VAL, ST_VAL_W, ST_CLR, ST_CLR_W}
    scan_state_t;
endpackage : field_point_pkg

// >>> rtl/entry_if.sv
`timescale 1ns/100ps
interface entry_if;
  import field_point_pkg::*;
  logic       req;
  logic       we;
  entry_idx_t idx;
  value_t     wdata;
  logic       done;
  value_t     rdata;
  modport client (output req, we, idx, wdata, input done, rdata);
  modport engine (input req, we, idx, wdata, output done, rdata);
endinterface : entry_if

// >>> rtl/bank_access.sv
`timescale 1ns/100ps
module bank_access #(
  parameter int AW = 16
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic [AW-1:0]             base,
  input  wire logic                      narrow,
  entry_if.engine                        eif,
  output logic                           ctl_req_r,
  output logic                           ctl_we_r,
  output logic [AW-1:0]                  ctl_addr_r,
  output field_point_pkg::value_t        ctl_wdata_r,
  input  wire field_point_pkg::value_t   ctl_rdata,
  input  wire logic                      ctl_ack
);
  import field_point_pkg::*;
  logic          busy_r;
  logic          hi_r;
  // Width held per access so a bank reload never splits an entry
  logic          pair_mode_r;
  logic [7:0]    lo_r;
  value_t        hold_r;
  wire  [AW-1:0] addr_wide  = base + AW'(eif.idx);
  wire  [AW-1:0] addr_pair  = base + AW'({eif.idx, 1'b0});
  wire  [AW-1:0] first_addr = narrow ? addr_pair : addr_wide;
  wire           take       = !busy_r && eif.req;
  wire           pair_step  = busy_r && ctl_ack && pair_mode_r && !hi_r;
  wire           finish     = busy_r && ctl_ack && !pair_step;
  wire  [15:0]   first_wd   = narrow ? {8'h00, eif.wdata[7:0]} : eif.wdata;
  wire  [15:0]   read_word  = pair_mode_r ? {ctl_rdata[7:0], lo_r} : ctl_rdata;

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_r      <= 1'b0;
      hi_r        <= 1'b0;
      lo_r        <= 8'h00;
      pair_mode_r <= 1'b0;
      hold_r      <= 16'h0000;
      ctl_req_r   <= 1'b0;
      ctl_we_r    <= 1'b0;
      ctl_addr_r  <= '0;
      ctl_wdata_r <= 16'h0000;
      eif.done    <= 1'b0;
      eif.rdata   <= 16'h0000;
    end else begin
      eif.done <= finish;
      if (take) begin
        busy_r      <= 1'b1;
        hi_r        <= 1'b0;
        ctl_req_r   <= 1'b1;
        ctl_we_r    <= eif.we;
        pair_mode_r <= narrow;
        ctl_addr_r  <= first_addr;
        ctl_wdata_r <= first_wd;
        hold_r      <= eif.wdata;
      end else if (pair_step) begin
        // Low byte at the lower register, then the high byte
        hi_r        <= 1'b1;
        lo_r        <= ctl_rdata[7:0];
        ctl_addr_r  <= ctl_addr_r + AW'(1);
        ctl_wdata_r <= {8'h00, hold_r[15:8]};
      end else if (finish) begin
        busy_r    <= 1'b0;
        ctl_req_r <= 1'b0;
        eif.rdata <= read_word;
      end
    end
  end

  req_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ctl_req_r && !ctl_ack |=> ctl_req_r && $stable(ctl_addr_r))
    else $error("bank request dropped or moved before acknowledge");
  pair_step_a: assert property (@(posedge mclk) disable iff (rst)
    pair_step |=> ctl_req_r && ctl_addr_r == $past(ctl_addr_r) + AW'(1))
    else $error("second register of a pair not addressed");
  done_after_a: assert property (@(posedge mclk) disable iff (rst)
    finish |=> eif.done && !ctl_req_r)
    else $error("entry completion not reported");
  pair_cov_c: cover property (@(posedge mclk) disable iff (rst) pair_step ##[1:20] finish);
endmodule : bank_access

// >>> rtl/field_point_register_bank.sv
`timescale 1ns/100ps
`include "field_point_params.svh"
module field_point_register_bank #(
  parameter int FP = `FP_COUNT,
  parameter int AW = 16
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Bank configuration
  input  wire logic                        cfg_bank_load,
  input  wire logic [AW-1:0]               cfg_base,
  input  wire logic                        cfg_narrow,
  input  wire logic                        cfg_force_en,
  input  wire field_point_pkg::link_mode_t cfg_link_mode,
  // Per-point configuration
  input  wire logic                        cfg_load,
  input  wire field_point_pkg::entry_idx_t cfg_point,
  input  wire logic                        cfg_is_sp,
  input  wire logic [1:0]                  cfg_dp,
  input  wire field_point_pkg::value_t     cfg_min,
  input  wire field_point_pkg::value_t     cfg_max,
  // Operator keys
  input  wire field_point_pkg::entry_idx_t op_point,
  input  wire logic                        op_up,
  input  wire logic                        op_down,
  // Display view
  input  wire field_point_pkg::entry_idx_t view_sel,
  output field_point_pkg::value_t          view_value_r,
  output logic [1:0]                       view_dp_r,
  output logic                             view_is_sp_r,
  // Controller holding registers
  output logic                             ctl_req_r,
  output logic                             ctl_we_r,
  output logic [AW-1:0]                    ctl_addr_r,
  output field_point_pkg::value_t          ctl_wdata_r,
  input  wire field_point_pkg::value_t     ctl_rdata,
  input  wire logic                        ctl_ack,
  // Serial link addressing
  input  wire logic [4:0]                  addr_sw,
  input  wire logic                        rx_addr_valid,
  input  wire logic [4:0]                  rx_addr,
  input  wire logic                        resp_done,
  output logic                             addr_hit_r,
  output logic                             tx_oe_n_r,
  output logic                             force_done_r
);
  import field_point_pkg::*;

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [AW-1:0]          base_r;
  logic                   narrow_r;
  logic                   force_en_r;
  link_mode_t             link_mode_r;
  logic [FP-1:0]          pt_is_sp_r;
  logic [FP-1:0][1:0]     pt_dp_r;
  logic [FP-1:0][15:0]    min_r;
  logic [FP-1:0][15:0]    max_r;
  logic [FP-1:0][15:0]    sp_val_r;
  logic [FP-1:0][15:0]    disp_val_r;
  logic [FP-1:0]          force_sel_r;
  logic [4:0]             mod_addr_r;
  logic                   reply_pend_r;
  scan_state_t            st_r;
  scan_state_t            st_nxt;
  entry_idx_t             pt_idx_r;

  entry_if eif ();

  function automatic value_t clamp(input value_t v, input value_t lo, input value_t hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  wire cfg_hit = cfg_load && (cfg_point < entry_idx_t'(FP));
  wire cfg_max_ok = cfg_max <= `VALUE_MAX;
  wire [15:0] cfg_max_eff = cfg_max_ok ? cfg_max : `VALUE_MAX;
  wire [15:0] cfg_min_eff = (cfg_min > cfg_max_eff) ? cfg_max_eff : cfg_min;

  always_ff @(posedge mclk) begin
    if (rst) begin
      base_r      <= `BASE_RST;
      narrow_r    <= 1'b0;
      force_en_r  <= 1'b0;
      link_mode_r <= LINK_RS232;
    end else if (cfg_bank_load) begin
      base_r      <= cfg_base;
      narrow_r    <= cfg_narrow;
      force_en_r  <= cfg_force_en;
      link_mode_r <= cfg_link_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pt_is_sp_r <= '0;
      pt_dp_r    <= '0;
      min_r      <= '0;
      for (int i = 0; i < FP; i++) max_r[i] <= `VALUE_MAX;
    end else if (cfg_hit) begin
      pt_is_sp_r[cfg_point] <= cfg_is_sp;
      pt_dp_r[cfg_point]    <= cfg_dp;
      min_r[cfg_point]      <= cfg_min_eff;
      max_r[cfg_point]      <= cfg_max_eff;
    end
  end

  // ----------------------------------------------------------------
  // Bank scan sequencer
  // ----------------------------------------------------------------
  wire last_pt   = pt_idx_r == entry_idx_t'(FP - 1);
  wire pt_is_sp  = pt_is_sp_r[pt_idx_r];
  wire flag_set  = eif.rdata[`FORCE_REQ_BIT];
  wire force_app = (st_r == ST_VAL_W) && eif.done;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_PT:    st_nxt = ST_PT_W;
      ST_PT_W:  if (eif.done) st_nxt = (last_pt && force_en_r) ? ST_FLG : ST_PT;
      ST_FLG:   st_nxt = ST_FLG_W;
      ST_FLG_W: if (eif.done) st_nxt = flag_set ? ST_VAL : ST_PT;
      ST_VAL:   st_nxt = ST_VAL_W;
      ST_VAL_W: if (eif.done) st_nxt = ST_CLR;
      ST_CLR:   st_nxt = ST_CLR_W;
      ST_CLR_W: if (eif.done) st_nxt = ST_PT;
    endcase
  end

  assign eif.req   = (st_r == ST_PT) || (st_r == ST_FLG) || (st_r == ST_VAL)
                     || (st_r == ST_CLR);
  assign eif.we    = ((st_r == ST_PT) && pt_is_sp) || (st_r == ST_CLR);
  assign eif.idx   = (st_r == ST_VAL) ? `FORCE_VALUE_OFS
                   : ((st_r == ST_FLG) || (st_r == ST_CLR)) ? `FORCE_FLAG_OFS
                   : pt_idx_r;
  assign eif.wdata = (st_r == ST_CLR) ? 16'h0000 : sp_val_r[pt_idx_r];

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r         <= ST_PT;
      pt_idx_r     <= 4'h0;
      force_sel_r  <= '0;
      force_done_r <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      force_done_r <= (st_r == ST_CLR_W) && eif.done;
      if ((st_r == ST_PT_W) && eif.done) pt_idx_r <= last_pt ? 4'h0 : pt_idx_r + 4'h1;
      if ((st_r == ST_FLG_W) && eif.done) force_sel_r <= eif.rdata[`FORCE_SEL_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Point values
  // ----------------------------------------------------------------
  wire [15:0] force_val = (eif.rdata > `VALUE_MAX) ? `VALUE_MAX : eif.rdata;
  wire [15:0] op_cur    = sp_val_r[op_point];
  wire        op_ok     = (op_point < entry_idx_t'(FP)) && pt_is_sp_r[op_point];
  wire [15:0] op_up_v   = clamp(op_cur + 16'h0001, min_r[op_point], max_r[op_point]);
  wire [15:0] op_dn_v   = (op_cur == 16'h0000) ? min_r[op_point]
                        : clamp(op_cur - 16'h0001, min_r[op_point], max_r[op_point]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < FP; i++) sp_val_r[i] <= `VALUE_RST;
    end else if (force_app) begin
      for (int i = 0; i < FP; i++) begin
        if (force_sel_r[i] && pt_is_sp_r[i]) sp_val_r[i] <= force_val;
      end
    end else if (cfg_hit) begin
      sp_val_r[cfg_point] <= clamp(sp_val_r[cfg_point], cfg_min_eff, cfg_max_eff);
    end else if (op_ok && (op_up ^ op_down)) begin
      sp_val_r[op_point] <= op_up ? op_up_v : op_dn_v;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      disp_val_r <= '0;
    end else if ((st_r == ST_PT_W) && eif.done && !pt_is_sp) begin
      disp_val_r[pt_idx_r] <= (eif.rdata > `VALUE_MAX) ? `VALUE_MAX : eif.rdata;
    end
  end

  wire        view_ok  = view_sel < entry_idx_t'(FP);
  wire [15:0] view_val = !view_ok ? 16'h0000
                       : pt_is_sp_r[view_sel] ? sp_val_r[view_sel] : disp_val_r[view_sel];

  always_ff @(posedge mclk) begin
    if (rst) begin
      view_value_r <= 16'h0000;
      view_dp_r    <= `DP_RST;
      view_is_sp_r <= 1'b0;
    end else begin
      view_value_r <= view_val;
      view_dp_r    <= view_ok ? pt_dp_r[view_sel] : `DP_RST;
      view_is_sp_r <= view_ok && pt_is_sp_r[view_sel];
    end
  end

  // ----------------------------------------------------------------
  // Link addressing and driver enable
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      mod_addr_r   <= 5'h00;
      addr_hit_r   <= 1'b0;
      reply_pend_r <= 1'b0;
      tx_oe_n_r    <= 1'b1;
    end else begin
      mod_addr_r   <= addr_sw;
      addr_hit_r   <= rx_addr_valid && (rx_addr == mod_addr_r);
      // Answer only after being addressed
      reply_pend_r <= addr_hit_r || (reply_pend_r && !resp_done);
      // Multidrop keeps the driver off unless answering
      tx_oe_n_r    <= !((link_mode_r == LINK_RS232) || reply_pend_r);
    end
  end

  bank_access #(.AW(AW)) u_access (
    .mclk        (mclk),
    .rst         (rst),
    .base        (base_r),
    .narrow      (narrow_r),
    .eif         (eif.engine),
    .ctl_req_r   (ctl_req_r),
    .ctl_we_r    (ctl_we_r),
    .ctl_addr_r  (ctl_addr_r),
    .ctl_wdata_r (ctl_wdata_r),
    .ctl_rdata   (ctl_rdata),
    .ctl_ack     (ctl_ack)
  );

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  logic [FP-1:0] force_mask;
  logic [FP-1:0] at_force;
  logic [FP-1:0] sp_over;
  logic [FP-1:0] disp_over;

  always_comb begin
    force_mask = '0;
    at_force   = '0;
    sp_over    = '0;
    disp_over  = '0;
    for (int i = 0; i < FP; i++) begin
      force_mask[i] = force_sel_r[i] && pt_is_sp_r[i];
      at_force[i]   = sp_val_r[i] == force_val;
      sp_over[i]    = sp_val_r[i] > `VALUE_MAX;
      disp_over[i]  = disp_val_r[i] > `VALUE_MAX;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sp_copy_a: assert property (@(posedge mclk) disable iff (rst)
    (st_r == ST_PT) && pt_is_sp |=> ctl_req_r && ctl_we_r
      && ctl_wdata_r == ($past(narrow_r) ? {8'h00, $past(sp_val_r[pt_idx_r][7:0])}
                                  : $past(sp_val_r[pt_idx_r])))
    else $error("setpoint not copied to its register");
  disp_fetch_a: assert property (@(posedge mclk) disable iff (rst)
    (st_r == ST_PT) && !pt_is_sp |=> ctl_req_r && !ctl_we_r)
    else $error("display point not fetched");
  force_clear_a: assert property (@(posedge mclk) disable iff (rst)
    force_app |-> ##[2:40] (ctl_req_r && ctl_we_r && ctl_wdata_r == 16'h0000))
    else $error("force flag entry not cleared");
  force_take_a: assert property (@(posedge mclk) disable iff (rst)
    force_app |=> ($past(force_mask) & ~at_force) == '0)
    else $error("selected setpoint missed the override");
  dp_fixed_a: assert property (@(posedge mclk) disable iff (rst)
    !cfg_load |=> $stable(pt_dp_r))
    else $error("decimal point moved without configuration");
  sp_bound_a: assert property (@(posedge mclk) disable iff (rst)
    op_ok && op_up && !op_down && !force_app && !cfg_hit
      |=> sp_val_r[$past(op_point)] <= max_r[$past(op_point)])
    else $error("setpoint adjusted beyond maximum");
  addr_hit_a: assert property (@(posedge mclk) disable iff (rst)
    rx_addr_valid && rx_addr == mod_addr_r |=> addr_hit_r)
    else $error("own address not recognised");
  tx_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    link_mode_r == LINK_RS422 && !reply_pend_r |=> tx_oe_n_r)
    else $error("multidrop driver on without a request");
  sp_range_a: assert property (@(posedge mclk) disable iff (rst)
    sp_over == '0)
    else $error("setpoint value above range");
  disp_range_a: assert property (@(posedge mclk) disable iff (rst)
    disp_over == '0)
    else $error("display value above range");
  addr_miss_a: assert property (@(posedge mclk) disable iff (rst)
    !(rx_addr_valid && rx_addr == mod_addr_r) |=> !addr_hit_r)
    else $error("foreign address recognised");
  scan_gap_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(ctl_req_r) |=> !ctl_req_r)
    else $error("entries issued without a gap");
  sp_floor_a: assert property (@(posedge mclk) disable iff (rst)
    op_ok && op_down && !op_up && !force_app && !cfg_hit
      |=> sp_val_r[$past(op_point)] >= min_r[$past(op_point)])
    else $error("setpoint adjusted below minimum");
  force_cov_c: cover property (@(posedge mclk) disable iff (rst) force_app ##[1:40] force_done_r);
  disp_cov_c: cover property (@(posedge mclk) disable iff (rst)
    (st_r == ST_PT_W) && eif.done && !pt_is_sp);
  op_cov_c: cover property (@(posedge mclk) disable iff (rst) op_ok && op_down);
  link_cov_c: cover property (@(posedge mclk) disable iff (rst)
    addr_hit_r ##1 reply_pend_r ##[1:20] resp_done);
endmodule : field_point_register_bank

// >>> test/ctl_model.sv
`timescale 1ns/100ps
module ctl_model
  import field_point_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        ctl_req_r,
  input  wire logic        ctl_we_r,
  input  wire logic [15:0] ctl_addr_r,
  input  wire value_t      ctl_wdata_r,
  input  wire logic [1:0]  lat,
  output value_t           ctl_rdata,
  output logic             ctl_ack
);
  value_t     mem [0:127];
  logic [2:0] cnt;

  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'h0000;
    end
    ctl_ack   = 1'b0;
    ctl_rdata = 16'h0000;
    cnt       = 3'h0;
  end

  // -------------------------------------------------------------------
  // Holding registers, answer only to requests
  // -------------------------------------------------------------------
  always @(posedge mclk) begin
    if (ctl_ack) begin
      ctl_ack   <= 1'b0;
      cnt       <= 3'h0;
      ctl_rdata <= ~ctl_rdata;
    end else if (ctl_req_r && cnt >= {1'b0, lat}) begin
      ctl_ack <= 1'b1;
      if (ctl_we_r) begin
        mem[ctl_addr_r[6:0]] <= ctl_wdata_r;
      end
      ctl_rdata <= mem[ctl_addr_r[6:0]];
    end else begin
      cnt       <= ctl_req_r ? cnt + 3'h1 : 3'h0;
      ctl_rdata <= ~ctl_rdata;
    end
  end
endmodule : ctl_model

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  import field_point_pkg::*;
  typedef struct {logic [1:0] kind; value_t val;} note_t;
  logic mclk = 0, rst = 1, cfg_bank_load = 0, cfg_narrow = 0, cfg_force_en = 0, cfg_load = 0;
  logic cfg_is_sp = 0, op_up = 0, op_down = 0, rx_addr_valid = 0, resp_done = 0;
  logic [15:0] cfg_base = 0, base_now = 0;
  link_mode_t cfg_link_mode = LINK_RS232;
  entry_idx_t cfg_point = 0, op_point = 0, view_sel = 0;
  logic [1:0] cfg_dp = 0, lat = 0, view_dp_r;
  value_t cfg_min = 0, cfg_max = 0, view_value_r, ctl_wdata_r, ctl_rdata;
  logic [4:0] addr_sw = 0, rx_addr = 0, sw;
  logic view_is_sp_r, ctl_req_r, ctl_we_r, ctl_ack, addr_hit_r, tx_oe_n_r, force_done_r;
  logic [15:0] ctl_addr_r;
  logic [31:0] rnd = 32'hfbdc;
  int n_fail = 0, n_checks = 0;
  note_t note_q [$];

  always #2.5 mclk = ~mclk;

  field_point_register_bank i_field_point_register_bank (.mclk(mclk), .rst(rst),
    .cfg_bank_load(cfg_bank_load), .cfg_base(cfg_base), .cfg_narrow(cfg_narrow),
    .cfg_force_en(cfg_force_en), .cfg_link_mode(cfg_link_mode), .cfg_load(cfg_load),
    .cfg_point(cfg_point), .cfg_is_sp(cfg_is_sp), .cfg_dp(cfg_dp), .cfg_min(cfg_min),
    .cfg_max(cfg_max), .op_point(op_point), .op_up(op_up), .op_down(op_down),
    .view_sel(view_sel), .view_value_r(view_value_r), .view_dp_r(view_dp_r),
    .view_is_sp_r(view_is_sp_r), .ctl_req_r(ctl_req_r), .ctl_we_r(ctl_we_r),
    .ctl_addr_r(ctl_addr_r), .ctl_wdata_r(ctl_wdata_r), .ctl_rdata(ctl_rdata),
    .ctl_ack(ctl_ack), .addr_sw(addr_sw), .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr),
    .resp_done(resp_done), .addr_hit_r(addr_hit_r), .tx_oe_n_r(tx_oe_n_r),
    .force_done_r(force_done_r));
  ctl_model i_ctl_model (.mclk(mclk), .ctl_req_r(ctl_req_r), .ctl_we_r(ctl_we_r),
    .ctl_addr_r(ctl_addr_r), .ctl_wdata_r(ctl_wdata_r), .lat(lat), .ctl_rdata(ctl_rdata),
    .ctl_ack(ctl_ack));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // -------------------------------------------------------------------
  // Monitor: events popped against the oldest note
  // -------------------------------------------------------------------
  task automatic take(input logic [1:0] k, input value_t v);
    note_t n;
    if (note_q.size() == 0) begin
      check({14'h0, k, v}, 32'hffff_ffff, "unexpected event");
    end else begin
      n = note_q.pop_front();
      check({14'h0, k, v}, {14'h0, n.kind, n.val}, "event");
    end
  endtask : take

  always @(posedge mclk) begin
    if (!rst) begin
      if (addr_hit_r === 1'b1) take(2'h0, 16'h0000);
      if ((ctl_req_r & ctl_ack & ctl_we_r) === 1'b1 && ctl_addr_r === base_now + 16'hc)
        take(2'h1, ctl_wdata_r);
      if (force_done_r === 1'b1) take(2'h2, 16'h0000);
    end
  end

  // -------------------------------------------------------------------
  // Driver tasks
  // -------------------------------------------------------------------
  task automatic bank(input logic [15:0] b, input logic nw, input logic fe, input link_mode_t m);
    @(posedge mclk);
    {cfg_bank_load, cfg_base, cfg_narrow, cfg_force_en, cfg_link_mode} <= {1'b1, b, nw, fe, m};
    base_now <= b;
    rnd = xs(rnd);
    lat      <= rnd[1:0];
    @(posedge mclk);
    cfg_bank_load <= 1'b0;
  endtask : bank

  task automatic cfg_pt(input entry_idx_t p, input logic sp, input logic [1:0] dp,
                        input value_t mn, input value_t mx);
    @(posedge mclk);
    {cfg_load, cfg_point, cfg_is_sp, cfg_dp, cfg_min, cfg_max} <= {1'b1, p, sp, dp, mn, mx};
    @(posedge mclk);
    cfg_load <= 1'b0;
  endtask : cfg_pt

  task automatic wait_acc(input logic [15:0] a, input logic we);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge mclk);
      if (ctl_req_r === 1'b1 && ctl_ack === 1'b1 && ctl_we_r === we && ctl_addr_r === a) break;
    end
    if (i == 3000) begin
      check(0, 1, "access wait timed out");
      conclude();
    end
  endtask : wait_acc

  task automatic view(input entry_idx_t p, input value_t v, input logic [1:0] dp);
    @(posedge mclk);
    view_sel <= p;
    tick(3);
    #1;
    check(view_value_r, v, "view value");
    check(view_dp_r, dp, "view dp");
  endtask : view

  task automatic two_scans(input logic [15:0] a);
    wait_acc(a, 1'b0);
    wait_acc(a, 1'b0);
  endtask : two_scans

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    tick(5);
    #1;
    check(ctl_req_r, 0, "request in reset");
    check(tx_oe_n_r, 1, "driver in reset");
    rst <= 1'b0;
    bank(16'h0020, 1'b0, 1'b1, LINK_RS422);
    cfg_pt(4'h3, 1'b1, 2'h1, 16'd100, 16'd200);
    cfg_pt(4'h1, 1'b0, 2'h3, 16'd0, 16'd9999);
    cfg_pt(4'h8, 1'b1, 2'h2, 16'd0, 16'd12500);
    cfg_pt(4'h5, 1'b1, 2'h0, 16'd7, 16'd50);
    @(negedge mclk);
    i_ctl_model.mem[7'h21] = 16'd1234;
    i_ctl_model.mem[7'h2a] = 16'd12000;
    @(posedge mclk);
    {op_point, op_up} <= {4'h3, 1'b1};
    tick(120);
    {op_up, op_down} <= 2'b01;
    tick(3);
    {op_point, op_down, op_up} <= {4'h1, 1'b0, 1'b1};
    tick(5);
    op_up <= 1'b0;
    two_scans(16'h002c);
    view(4'h3, 16'd197, 2'h1);
    check(view_is_sp_r, 1, "view role");
    view(4'h1, 16'd1234, 2'h3);
    check(view_is_sp_r, 0, "view role");
    view(4'ha, 16'd9999, 2'h0);
    view(4'h5, 16'd7, 2'h0);
    check(i_ctl_model.mem[7'h23], 16'd197, "setpoint copy");
    check(i_ctl_model.mem[7'h25], 16'd7, "setpoint copy");
    @(negedge mclk);
    i_ctl_model.mem[7'h2d] = 16'd4321;
    i_ctl_model.mem[7'h2c] = 16'h810a;
    note_q.push_back('{2'h1, 16'h0000});
    note_q.push_back('{2'h2, 16'h0000});
    wait_acc(16'h002c, 1'b1);
    tick(3);
    check(i_ctl_model.mem[7'h2c], 0, "flag cleared");
    view(4'h3, 16'd4321, 2'h1);
    view(4'h8, 16'd4321, 2'h2);
    view(4'h1, 16'd1234, 2'h3);
    view(4'h5, 16'd7, 2'h0);
    two_scans(16'h002c);
    check(i_ctl_model.mem[7'h23], 16'd4321, "forced copy");
    bank(16'h0040, 1'b1, 1'b0, LINK_RS232);
    @(negedge mclk);
    i_ctl_model.mem[7'h42] = 16'h0034;
    i_ctl_model.mem[7'h43] = 16'h0012;
    two_scans(16'h0056);
    check(i_ctl_model.mem[7'h46][7:0], 8'he1, "low byte");
    check(i_ctl_model.mem[7'h47][7:0], 8'h10, "high byte");
    view(4'h1, 16'h1234, 2'h3);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) bank(16'h0040, 1'b1, 1'b0, LINK_RS422);
      rnd = xs(rnd);
      sw = rnd[4:0];
      @(posedge mclk);
      addr_sw <= sw;
      tick(2);
      rx_addr       <= i[0] ? sw : sw ^ {rnd[8:5], 1'b1};
      rx_addr_valid <= 1'b1;
      if (i[0]) note_q.push_back('{2'h0, 16'h0000});
      @(posedge mclk);
      rx_addr_valid <= 1'b0;
      tick(4);
      #1;
      check(tx_oe_n_r, (i < 4) ? 0 : !i[0], "transmit enable");
      @(posedge mclk);
      resp_done <= 1'b1;
      @(posedge mclk);
      resp_done <= 1'b0;
      tick(3);
      #1;
      check(tx_oe_n_r, (i < 4) ? 0 : 1, "transmit release");
    end
    tick(10);
    check(note_q.size(), 0, "events left over");
    conclude();
  end
endmodule : tb
